/* File: ref_pulse_src.sv */
// Partner model: precise reference pulse source driving the reference input pin
`timescale 1ns/100ps
`default_nettype none
module ref_pulse_src #(
  parameter int HIGH_CYCLES = 100
) (
  input  wire logic clk,
  input  wire logic go,
  output logic      pin
);
  int cnt = 0;
  // Idle low between pulses, as a real reference line sits between seconds
  always @(posedge clk) begin
    if (go) begin
      cnt <= HIGH_CYCLES;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign pin = (cnt > 0);
endmodule
`default_nettype wire

/* File: rtc2_control.sv */
// Counter 2 control: AXI4-Lite registers, strobes, pulse output, locking and status
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module rtc2_control (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [13:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [13:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        referencePulsePin,
  input  wire logic        debugBreak,
  output logic             secondPulsePin,
  output logic             calendarClear,
  output logic             calendarWrite,
  output logic [7:0]       calendarData,
  output logic             irq
);
  import rtc2_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0]  ctrl2_reg;
  logic [2:0]  ctrl1_reg;
  logic [2:0]  irqStat_reg;
  logic [2:0]  irqMask_reg;
  logic        run2Flag_reg;
  logic        mode2Flag_reg;
  logic        lockFlag_reg;
  logic [2:0]  lagCount_reg;
  logic [15:0] secCount_reg;
  logic        pulseLevel_reg;
  logic [13:0] awAddr_reg;
  logic        awHeld_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;
  logic        wHeld_reg;
  logic        doneSeen_reg;

  wire logic lfTick;
  wire logic [19:0] count2;
  wire logic count2Done;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel decode
  wire logic [13:0] wrAddr  = awHeld_reg ? awAddr_reg : s_axi_awaddr;
  wire logic [31:0] wrData  = wHeld_reg ? wData_reg : s_axi_wdata;
  wire logic [3:0]  wrStrb  = wHeld_reg ? wStrb_reg : s_axi_wstrb;
  // Held or taken at this edge; ready must still rise while valid waits
  wire logic        awHave  = awHeld_reg | (s_axi_awvalid & s_axi_awready);
  wire logic        wHave   = wHeld_reg | (s_axi_wvalid & s_axi_wready);
  // Decodes act only once both halves are held, so strobes fire once
  wire logic        wrFire  = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
  wire logic        lane0   = wrStrb[0];
  wire logic        wrCtrl2 = wrFire & lane0 & (wrAddr == CTRL2_ADDR);
  wire logic        wrCtrl1 = wrFire & lane0 & (wrAddr == CTRL1_ADDR);
  wire logic        wrIrqS  = wrFire & lane0 & (wrAddr == IRQ_STAT_ADDR);
  wire logic        wrIrqM  = wrFire & lane0 & (wrAddr == IRQ_MASK_ADDR);
  wire logic        wrCal   = wrFire & lane0 & (wrAddr == CAL_DATA_ADDR);
  wire logic        wrKnown = (wrAddr == CTRL2_ADDR) | (wrAddr == CTRL1_ADDR)
                            | (wrAddr == IRQ_STAT_ADDR) | (wrAddr == IRQ_MASK_ADDR)
                            | (wrAddr == CAL_DATA_ADDR) | (wrAddr == STATUS_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Control decode
  counter_ctrl_t ctrl2;
  assign ctrl2.start       = ctrl2_reg[C2_START];
  assign ctrl2.measureMode = ctrl2_reg[C2_MODE];
  assign ctrl2.pulseEnable = ctrl2_reg[C2_PULSE];
  assign ctrl2.refSelect   = ctrl2_reg[C2_REFSEL];
  assign ctrl2.windowSel   = ctrl2_reg[C2_WIN_HI:C2_WIN_LO];

  // Strobes are one-cycle pulses; storage never keeps them, so reads show 0
  wire logic rateInit  = wrCtrl2 & wrData[C2_RATE_COUNTERS_INIT_STROBE];
  wire logic calInit   = wrCtrl2 & wrData[C2_RSTCAL];
  wire logic anyStart  = ctrl2.start | ctrl1_reg[C1_START];
  wire logic freeze    = debugBreak & anyStart;
  wire logic secWrap   = lfTick & ~freeze & (secCount_reg == 16'(SECOND_TICKS / 2 - 1));
  wire logic refLevel  = ctrl2.refSelect ? pulseLevel_reg : referencePulsePin;
  wire logic lagDone   = lfTick & (lagCount_reg == 3'(LAG_LF_CYCLES - 1));
  wire logic run2Now   = ctrl2.start & ~(ctrl2.measureMode & count2Done);
  wire logic pending   = (run2Flag_reg != run2Now) | (mode2Flag_reg != ctrl2.measureMode);
  wire logic doneRise  = count2Done & ~doneSeen_reg;
  wire logic lockRise  = ctrl1_reg[C1_HOLD] & ~lockFlag_reg;
  wire logic [2:0] events = {lockRise, doneRise, secWrap & ~pulseLevel_reg};
  wire logic [7:0] statusByte = {3'b000, mode2Flag_reg, ctrl1_reg[C1_MODE], run2Flag_reg,
                                 ctrl1_reg[C1_START], lockFlag_reg};

  ////////////////////////////////////////////////////////////////////////////
  // Read decode
  wire logic [7:0] rdByte =
      (s_axi_araddr == CTRL2_ADDR)    ? ctrl2_reg :
      (s_axi_araddr == STATUS_ADDR)   ? statusByte :
      (s_axi_araddr == CTRL1_ADDR)    ? {5'b00000, ctrl1_reg} :
      (s_axi_araddr == IRQ_STAT_ADDR) ? {5'b00000, irqStat_reg} :
      (s_axi_araddr == IRQ_MASK_ADDR) ? {5'b00000, irqMask_reg} :
      (s_axi_araddr == CAL_DATA_ADDR) ? calendarData : 8'h00;
  wire logic rdKnown = (s_axi_araddr == CTRL2_ADDR) | (s_axi_araddr == STATUS_ADDR)
                     | (s_axi_araddr == CTRL1_ADDR) | (s_axi_araddr == IRQ_STAT_ADDR)
                     | (s_axi_araddr == IRQ_MASK_ADDR) | (s_axi_araddr == CAL_DATA_ADDR);
  wire logic rdFire  = s_axi_arvalid & s_axi_arready;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules
  rtc2_lf_tick u_tick (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .tick (lfTick)
  );

  rtc2_measure u_meas (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .lfTick   (lfTick),
    .run      (ctrl2.start),
    .freeze   (freeze),
    .clear    (rateInit),
    .ctrl     (ctrl2),
    .refLevel (refLevel),
    .count    (count2),
    .done     (count2Done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshake
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awHeld_reg    <= 1'b0;
      wHeld_reg     <= 1'b0;
      awAddr_reg    <= 14'h0000;
      wData_reg     <= 32'h00000000;
      wStrb_reg     <= 4'h0;
    end else if (ce) begin
      s_axi_awready <= ~awHave & ~s_axi_bvalid;
      s_axi_wready  <= ~wHave & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (awHeld_reg && wHeld_reg && !s_axi_bvalid) begin
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wrKnown ? RESP_OKAY : RESP_SLVERR;
        awHeld_reg    <= 1'b0;
        wHeld_reg     <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rdByte};
        s_axi_rresp  <= rdKnown ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; writes only act when both halves are held
  wire logic wrNow = awHeld_reg & wHeld_reg & ~s_axi_bvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl2_reg   <= CTRL2_RESET;
      ctrl1_reg   <= 3'b000;
      irqMask_reg <= 3'b000;
    end else if (ce && wrNow) begin
      if (wrCtrl2) ctrl2_reg <= wrData[7:0] & ~(8'h01 << C2_RATE_COUNTERS_INIT_STROBE) & ~(8'h01 << C2_RSTCAL);
      if (wrCtrl1) ctrl1_reg <= wrData[2:0];
      if (wrIrqM)  irqMask_reg <= wrData[2:0];
    end
  end

  // Calendar outputs: init pulse and gated write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      calendarClear <= 1'b0;
      calendarWrite <= 1'b0;
      calendarData  <= 8'h00;
    end else if (ce) begin
      calendarClear <= wrNow & calInit;
      calendarWrite <= wrNow & wrCal & lockFlag_reg;
      if (wrNow && wrCal && lockFlag_reg) calendarData <= wrData[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter 2 run and mode status flags lag the control bits by up to four low-frequency ticks; the lock flag follows hold in one clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lagCount_reg  <= 3'b000;
      run2Flag_reg  <= 1'b0;
      mode2Flag_reg <= 1'b0;
      lockFlag_reg  <= 1'b0;
      doneSeen_reg  <= 1'b0;
    end else if (ce) begin
      doneSeen_reg <= count2Done;
      lockFlag_reg <= ctrl1_reg[C1_HOLD];
      if (!pending) lagCount_reg <= 3'b000;
      else if (lagDone) begin
        lagCount_reg  <= 3'b000;
        run2Flag_reg  <= run2Now;
        mode2Flag_reg <= ctrl2.measureMode;
      end else if (lfTick) lagCount_reg <= lagCount_reg + 3'b001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-second pulse: high half, low half
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      secCount_reg   <= 16'h0000;
      pulseLevel_reg <= 1'b0;
      secondPulsePin <= 1'b0;
    end else if (ce) begin
      if (lfTick && !freeze) secCount_reg <= secWrap ? 16'h0000 : secCount_reg + 16'h0001;
      if (secWrap) pulseLevel_reg <= ~pulseLevel_reg;
      secondPulsePin <= ctrl2.pulseEnable & pulseLevel_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: set wins over write-one clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStat_reg <= 3'b000;
      irq         <= 1'b0;
    end else if (ce) begin
      irqStat_reg <= (irqStat_reg & ~((wrNow & wrIrqS) ? wrData[2:0] : 3'b000)) | events;
      irq         <= |(irqStat_reg & irqMask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_init_self_clear;
    @(posedge clk) disable iff (rst) ce |-> !ctrl2_reg[C2_RATE_COUNTERS_INIT_STROBE] && !ctrl2_reg[C2_RSTCAL];
  endproperty
  a_init_self_clear: assert property (p_init_self_clear)
    else $error("init strobe bit held");

  property p_cal_gate;
    @(posedge clk) disable iff (rst) calendarWrite |-> $past(lockFlag_reg);
  endproperty
  a_cal_gate: assert property (p_cal_gate)
    else $error("calendar write without hold");

  property p_pulse_off;
    @(posedge clk) disable iff (rst) ce && !ctrl2.pulseEnable |=> !secondPulsePin;
  endproperty
  a_pulse_off: assert property (p_pulse_off)
    else $error("pulse while disabled");

  property p_cal_clear;
    @(posedge clk) disable iff (rst) ce && wrNow && calInit |=> calendarClear;
  endproperty
  a_cal_clear: assert property (p_cal_clear)
    else $error("calendar clear missed");

  property p_rate_clear;
    @(posedge clk) disable iff (rst) ce && wrNow && rateInit |=> count2 == 20'h00000;
  endproperty
  a_rate_clear: assert property (p_rate_clear)
    else $error("rate counter not cleared");

  property p_freeze;
    @(posedge clk) disable iff (rst) ce && freeze && !(wrNow && rateInit) |=> $stable(count2);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("counter moved in break");

  property p_stop;
    @(posedge clk) disable iff (rst)
      !ctrl2.start && $past(!ctrl2.start) && !$past(rateInit) |-> $stable(count2);
  endproperty
  a_stop: assert property (p_stop)
    else $error("stopped counter moved");

  property p_lag;
    @(posedge clk) disable iff (rst) ce && pending && lagDone |=>
      run2Flag_reg == $past(run2Now) && mode2Flag_reg == $past(ctrl2.measureMode);
  endproperty
  a_lag: assert property (p_lag)
    else $error("status lag too long");

  property p_ref_loop;
    @(posedge clk) disable iff (rst) ctrl2.refSelect |-> refLevel == pulseLevel_reg;
  endproperty
  a_ref_loop: assert property (p_ref_loop)
    else $error("loopback reference wrong");

endmodule
`default_nettype wire

/* File: rtc2_lf_tick.sv */
// Low-frequency tick generator derived from the system clock
`timescale 1ns/100ps
`default_nettype none
module rtc2_lf_tick (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  output logic      tick
);
  import rtc2_pkg::*;

  logic [11:0] divCount_reg;
  wire  logic  wrap = (divCount_reg == 12'(LF_DIV - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divCount_reg <= 12'h000;
      tick         <= 1'b0;
    end else if (ce) begin
      divCount_reg <= wrap ? 12'h000 : divCount_reg + 12'h001;
      tick         <= wrap;
    end
  end
endmodule
`default_nettype wire

/* File: rtc2_measure.sv */
// Counter 2 rate counter and window measurement engine
`timescale 1ns/100ps
`default_nettype none
module rtc2_measure (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic          lfTick,
  input  wire logic          run,
  input  wire logic          freeze,
  input  wire logic          clear,
  input  wire rtc2_pkg::counter_ctrl_t ctrl,
  input  wire logic          refLevel,
  output logic [19:0]        count,
  output logic               done
);
  import rtc2_pkg::*;

  logic       refPrev_reg;
  logic [4:0] periods_reg;
  logic       inWindow_reg;
  wire  logic refRise  = refLevel & ~refPrev_reg;
  wire  logic refFall  = ~refLevel & refPrev_reg;
  wire  logic highMode = (ctrl.windowSel == 2'(WIN_HIGH));
  wire  logic lastEdge = (periods_reg == window_periods(ctrl.windowSel) - 5'h01);
  wire  logic winOpen  = ~inWindow_reg & ~done & refRise;
  wire  logic winClose = inWindow_reg & (highMode ? refFall : (refRise & lastEdge));
  wire  logic countEn  = run & ~freeze & lfTick;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refPrev_reg  <= 1'b0;
      periods_reg  <= 5'h00;
      inWindow_reg <= 1'b0;
      count        <= 20'h00000;
      done         <= 1'b0;
    end else if (ce) begin
      refPrev_reg <= refLevel;
      if (clear || !run) begin
        periods_reg  <= 5'h00;
        inWindow_reg <= 1'b0;
        done         <= 1'b0;
        if (clear) count <= 20'h00000;
      end else if (!freeze) begin
        if (!ctrl.measureMode) begin
          if (countEn) count <= count + 20'h00001;
        end else begin
          if (winOpen) inWindow_reg <= 1'b1;
          if (winClose) begin
            inWindow_reg <= 1'b0;
            done         <= 1'b1;
          end else if (inWindow_reg && refRise) begin
            periods_reg <= periods_reg + 5'h01;
          end
          if ((inWindow_reg || winOpen) && countEn && !winClose) count <= count + 20'h00001;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtc2_pkg.sv */
// Package: register map, field positions, timing counts and carriers for the counter 2 control
package rtc2_pkg;

  // Register byte addresses (printed offsets are not all multiples of four: index * 4)
  localparam logic [11:0] CTRL2_INDEX    = 12'hfa1;
  localparam logic [13:0] CTRL2_ADDR     = {CTRL2_INDEX, 2'b00};
  localparam logic [13:0] STATUS_ADDR    = 14'h0010;
  localparam logic [13:0] CTRL1_ADDR     = 14'h0014;
  localparam logic [13:0] IRQ_STAT_ADDR  = 14'h0018;
  localparam logic [13:0] IRQ_MASK_ADDR  = 14'h001c;
  localparam logic [13:0] CAL_DATA_ADDR  = 14'h0020;

  // Control register two fields
  localparam int C2_START  = 7;
  localparam int C2_MODE   = 6;
  localparam int C2_RATE_COUNTERS_INIT_STROBE = 5;
  localparam int C2_RSTCAL = 4;
  localparam int C2_PULSE  = 3;
  localparam int C2_REFSEL = 2;
  localparam int C2_WIN_HI = 1;
  localparam int C2_WIN_LO = 0;
  localparam logic [7:0] CTRL2_RESET = 8'h00;

  // Own control register one: start1, mode1, hold
  localparam int C1_START = 2;
  localparam int C1_MODE  = 1;
  localparam int C1_HOLD  = 0;

  // Status bits
  localparam int S_LOCK  = 0;
  localparam int S_RUN1  = 1;
  localparam int S_RUN2  = 2;
  localparam int S_MODE2 = 4;

  // Interrupt events
  localparam int EV_SECOND = 0;
  localparam int EV_DONE2  = 1;
  localparam int EV_LOCK   = 2;

  // Low-frequency clock and status lag, 4 periods
  localparam int LF_HZ         = 32768;
  localparam int CLK_HZ        = 125000000;
  localparam int LAG_LF_CYCLES = 4;
  localparam int LF_DIV        = CLK_HZ / LF_HZ;
  localparam int SECOND_TICKS  = LF_HZ;
  localparam int PULSE_TICKS   = LF_HZ / 2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic       start;
    logic       measureMode;
    logic       pulseEnable;
    logic       refSelect;
    logic [1:0] windowSel;
  } counter_ctrl_t;

  typedef enum logic [1:0] {
    WIN_HIGH,
    WIN_ONE,
    WIN_FOUR,
    WIN_SIXTEEN
  } window_t;

  function automatic logic [4:0] window_periods(input logic [1:0] sel);
    unique case (sel)
      2'b00:   window_periods = 5'h01;
      2'b01:   window_periods = 5'h01;
      2'b10:   window_periods = 5'h04;
      default: window_periods = 5'h10;
    endcase
  endfunction

endpackage

/* File: rtc_counter2_measure_control_tb.sv */
// Testbench: register, strobe, calendar lock, interrupt and measurement scenarios
`timescale 1ns/100ps
`default_nettype none
module rtc_counter2_measure_control_tb;
  import rtc2_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, dbg = 1'b0, refGo = 1'b0;
  logic [13:0] awaddr = '0, araddr = '0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, refPin, secPin, calClr, calWr, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  calData;
  int errTotal = 0, nCompared = 0, nCalWr = 0, nCalClr = 0;
  logic [31:0] rd;
  logic [1:0]  rs;
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  rtc2_control rtc2_control_inst (
    .clk(clk), .rst(rst), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .referencePulsePin(refPin), .debugBreak(dbg), .secondPulsePin(secPin),
    .calendarClear(calClr), .calendarWrite(calWr), .calendarData(calData), .irq(irq)
  );
  ref_pulse_src #(.HIGH_CYCLES(2 * LF_DIV)) ref_pulse_src_inst (
    .clk(clk), .go(refGo), .pin(refPin)
  );
  always @(posedge clk) begin
    if (calWr === 1'b1) nCalWr++;
    if (calClr === 1'b1) nCalClr++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    nCompared++;
    if (seen !== exp) begin
      errTotal++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Master holds each channel until its own ready, response after both
  task automatic axiWrite(input logic [13:0] a, input logic [31:0] d, output logic [1:0] r);
    bit awOpen, wOpen;
    int n;
    awOpen = 1;
    wOpen = 1;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awOpen && awready === 1'b1) begin awOpen = 0; awvalid <= 1'b0; end
      if (wOpen && wready === 1'b1) begin wOpen = 0; wvalid <= 1'b0; end
    end while (!(awOpen == 0 && wOpen == 0 && bvalid === 1'b1) && n < 200);
    r = bresp;
    bready <= 1'b0;
    check({31'h0, n < 200}, 32'h1, "write answer");
    @(posedge clk);
  endtask
  task automatic axiRead(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 200);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    check({31'h0, n < 200}, 32'h1, "read answer");
    @(posedge clk);
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    axiWrite(a, d, rs);
    check({30'h0, rs}, {30'h0, RESP_OKAY}, "write okay");
  endtask
  // Poll one status bit, giving up after LF_DIV + 4 status reads
  task automatic waitBit(input int b, input logic v, input string msg);
    int n;
    n = 0;
    do begin
      axiRead(STATUS_ADDR, rd, rs);
      n++;
    end while (rd[b] !== v && n < LF_DIV + 4);
    check({31'h0, rd[b]}, {31'h0, v}, msg);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    axiRead(CTRL2_ADDR, rd, rs);
    check(rd, {24'h0, CTRL2_RESET}, "ctrl2 reset");
    axiRead(STATUS_ADDR, rd, rs);
    check(rd, 32'h0, "status reset");
    axiRead(14'h3ffc, rd, rs);
    check({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped read");
    axiWrite(14'h3ff8, 32'hff, rs);
    check({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped write");
    check({31'h0, secPin}, 32'h0, "pulse off");
    $display("test reset done");
  endtask
  task automatic t_strobes;
    wr(CTRL2_ADDR, 32'h30);
    repeat (4) @(posedge clk);
    check(nCalClr, 1, "calendar clear");
    axiRead(CTRL2_ADDR, rd, rs);
    check(rd, 32'h0, "strobes self-clear");
    $display("test strobes done");
  endtask
  task automatic t_calendar;
    wr(CAL_DATA_ADDR, 32'h5a);
    repeat (3) @(posedge clk);
    check(nCalWr, 0, "write without hold");
    wr(CTRL1_ADDR, 32'h1);
    waitBit(S_LOCK, 1'b1, "lock");
    wr(CAL_DATA_ADDR, 32'ha5);
    repeat (3) @(posedge clk);
    check(nCalWr, 1, "write under hold");
    check({24'h0, calData}, 32'ha5, "calendar data");
    check({31'h0, irq}, 32'h0, "irq masked");
    wr(IRQ_MASK_ADDR, 32'h4);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h1, "irq unmasked");
    wr(IRQ_STAT_ADDR, 32'h4);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h0, "irq cleared");
    wr(CTRL1_ADDR, 32'h0);
    waitBit(S_LOCK, 1'b0, "unlock");
    $display("test calendar done");
  endtask
  task automatic t_run;
    wr(CTRL2_ADDR, 32'h80);
    waitBit(S_RUN2, 1'b1, "free run started");
    check({31'h0, rd[S_MODE2]}, 32'h0, "free run mode");
    wr(CTRL2_ADDR, 32'h00);
    waitBit(S_RUN2, 1'b0, "stopped");
    wr(CTRL2_ADDR, 32'hc0);
    waitBit(S_MODE2, 1'b1, "measure mode");
    check({31'h0, rd[S_RUN2]}, 32'h1, "measuring");
    refGo <= 1'b1;
    @(posedge clk);
    refGo <= 1'b0;
    repeat (2 * LF_DIV + 8) @(posedge clk);
    waitBit(S_RUN2, 1'b0, "window ended");
    axiRead(IRQ_STAT_ADDR, rd, rs);
    check({31'h0, rd[EV_DONE2]}, 32'h1, "done event");
    // One-period window, with a debugger break inside it
    wr(IRQ_STAT_ADDR, 32'h2);
    wr(CTRL2_ADDR, 32'he1);
    refGo <= 1'b1;
    repeat (8) @(posedge clk);
    refGo <= 1'b0;
    dbg <= 1'b1;
    repeat (LF_DIV) @(posedge clk);
    dbg <= 1'b0;
    repeat (LF_DIV + 8) @(posedge clk);
    axiRead(IRQ_STAT_ADDR, rd, rs);
    check({31'h0, rd[EV_DONE2]}, 32'h0, "window still open");
    refGo <= 1'b1;
    @(posedge clk);
    refGo <= 1'b0;
    repeat (4) @(posedge clk);
    axiRead(IRQ_STAT_ADDR, rd, rs);
    check({31'h0, rd[EV_DONE2]}, 32'h1, "window closed");
    wr(CTRL2_ADDR, 32'h00);
    waitBit(S_MODE2, 1'b0, "mode off");
    $display("test run done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_strobes();
    t_calendar();
    t_run();
    test_done();
  end
  initial begin
    #(100000 * 8);
    errTotal++;
    test_done();
  end
endmodule
`default_nettype wire
